// [include/lwt_pkg.sv]
// constants, register map and mode codes of the low power wake timer
// assumes a byte wide register port with 16-bit addresses on the system clock side
package lwt_pkg;

	// counter geometry
	localparam int          LWT_CNT_W      = 24;
	localparam logic [23:0] LWT_CNT_ONE    = 24'h000001;
	localparam logic [23:0] LWT_CNT_RST    = 24'h000000;
	localparam logic [23:0] LWT_CMP_RST    = 24'hffffff;
	localparam logic [7:0]  LWT_BYTE_RST   = 8'h00;

	// register offsets
	localparam logic [15:0] LWT_CNT_LO_OFS   = 16'h0095;
	localparam logic [15:0] LWT_CNT_MID_OFS  = 16'h0096;
	localparam logic [15:0] LWT_CNT_HI_OFS   = 16'h0097;
	localparam logic [15:0] LWT_LOAD_ST_OFS  = 16'h00ad;
	localparam logic [15:0] LWT_CAP_CTL_OFS  = 16'h62b0;
	localparam logic [15:0] LWT_CAP_ST_OFS   = 16'h62b1;
	localparam logic [15:0] LWT_CAP_LO_OFS   = 16'h62b2;
	localparam logic [15:0] LWT_CAP_MID_OFS  = 16'h62b3;
	localparam logic [15:0] LWT_CAP_HI_OFS   = 16'h62b4;

	// capture control fields
	localparam int          LWT_PORT_MSB   = 4;
	localparam int          LWT_PORT_LSB   = 3;
	localparam int          LWT_PIN_MSB    = 2;
	localparam int          LWT_PIN_LSB    = 0;
	localparam logic [1:0]  LWT_PORT_OFF   = 2'h3;
	localparam logic [1:0]  LWT_PORT_TWO   = 2'h2;
	localparam logic [2:0]  LWT_PIN_RST    = 3'h7;
	localparam logic [2:0]  LWT_PIN_LIM_P2 = 3'h6;

	// padding for narrow read fields
	localparam logic [6:0]  LWT_PAD7       = 7'h00;
	localparam logic [2:0]  LWT_PAD3       = 3'h0;

	// dma trigger index per device variant
	localparam logic [4:0]  LWT_DMA_IDX_A  = 5'h1c;
	localparam logic [4:0]  LWT_DMA_IDX_B  = 5'h10;

	// power modes of the chip
	typedef enum logic [2:0] {
		LWT_PM_ACTIVE  = 3'b000,
		LWT_PM_IDLE    = 3'b001,
		LWT_PM_LIGHT   = 3'b010,
		LWT_PM_MEDIUM  = 3'b011,
		LWT_PM_DEEPEST = 3'b100
	} lwt_pmode_e;

endpackage

// [design/lwt_top.sv]
// low power wake timer: 24-bit slow clock counter with compare, wake and capture
// assumes slow_clk_i is the 32 kHz clock level, sampled on clk_i (100 MHz)
// assumes a simple byte register port; reads answer one cycle after the strobe

// Contract
// - 24-bit counter runs on slow clock, held at zero in deepest
// - low byte read snapshots count for mid/high
// - counts in all modes but deepest, cleared there
// - readable count refreshes only on slow rising edge
// - match on slow edge sets flag, enable gates
// - low compare write loads latest three bytes
// - low compare write ignored while not load ready
// - load ready low during transfer, high afterwards
// - compare event wakes chip from light/medium sleep
// - compare value resets to all ones
// - compare event pulses dma trigger, index per variant
// - selected pin flag rise captures count
// - captured value is count plus one
// - valid flag sticky, blocks capture, cleared by zero
// - pin change only while port three, or when writing port three
// - port three or bad pin disables capture
module lwt_top
	import lwt_pkg::*;
#(
	parameter logic [4:0] DMA_TRIG_INDEX = LWT_DMA_IDX_B
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       slow_clk_i,
	input  lwt_pmode_e      power_mode_i,
	input  wire logic [15:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       compare_irq_enable_i,
	input  wire logic       compare_flag_clr_i,
	input  wire logic [23:0] port_irq_flags_i,
	output logic            compare_irq_flag_o,
	output logic            compare_irq_req_o,
	output logic            dma_trigger_o,
	output logic      [4:0] dma_trigger_index_o,
	output logic            wake_o,
	output logic            slow_clock_level_o
);

	// slow clock synchroniser and edge detect
	logic        slow_s1_ff;
	logic        slow_s2_ff;
	logic        slow_s3_ff;
	logic        slow_rise;

	// counter state
	logic [23:0] cnt_ff;
	logic [23:0] nxt_cnt;
	logic [23:0] cnt_inc;
	logic [23:0] vis_cnt_ff;
	logic [23:0] snap_ff;

	// compare state
	logic [23:0] cmp_ff;
	logic [7:0]  cmp_hi_ff;
	logic [7:0]  cmp_mid_ff;
	logic [7:0]  cmp_lo_ff;
	logic        load_pend_ff;
	logic        cmp_event;
	logic        cmp_flag_ff;
	logic        irq_req_ff;
	logic        dma_ff;
	logic        wake_ff;

	// capture state
	logic [1:0]  cap_port_ff;
	logic [2:0]  cap_pin_ff;
	logic        cap_en;
	logic [4:0]  pin_index;
	logic        pin_sel;
	logic        pin_s1_ff;
	logic        pin_s2_ff;
	logic        pin_prev_ff;
	logic        cap_event;
	logic        cap_valid_ff;
	logic [23:0] cap_val_ff;

	// register port
	logic        wr_cnt_lo;
	logic        wr_cnt_mid;
	logic        wr_cnt_hi;
	logic        wr_cap_ctl;
	logic        wr_cap_st;
	logic        rd_cnt_lo;
	logic        load_ok;
	logic        ctl_ok;
	logic        running;
	logic        sys_awake;
	logic        sleeping;
	logic [7:0]  rd_mux;
	logic [7:0]  rdata_ff;

	// power mode decode
	assign running   = (power_mode_i != LWT_PM_DEEPEST);
	assign sys_awake = (power_mode_i == LWT_PM_ACTIVE) || (power_mode_i == LWT_PM_IDLE);
	assign sleeping  = (power_mode_i == LWT_PM_LIGHT) || (power_mode_i == LWT_PM_MEDIUM);

	// slow clock level passes two flops before anyone looks at it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			slow_s1_ff <= 1'b0;
			slow_s2_ff <= 1'b0;
			slow_s3_ff <= 1'b0;
		end else begin
			slow_s1_ff <= slow_clk_i;
			slow_s2_ff <= slow_s1_ff;
			slow_s3_ff <= slow_s2_ff;
		end
	end

	// a rising edge seen after synchronising is one 32 kHz tick
	assign slow_rise = slow_s2_ff & ~slow_s3_ff;

	// free running count; deepest sleep loses it, so it is held at zero there
	assign cnt_inc = cnt_ff + LWT_CNT_ONE;
	assign nxt_cnt = !running ? LWT_CNT_RST : (slow_rise ? cnt_inc : cnt_ff);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_ff <= LWT_CNT_RST;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// readable copy only follows the counter while the system clock runs,
	// so after a wake it stays stale until the next slow rising edge
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			vis_cnt_ff <= LWT_CNT_RST;
		end else if (!running) begin
			vis_cnt_ff <= LWT_CNT_RST;
		end else if (slow_rise && sys_awake) begin
			vis_cnt_ff <= cnt_inc;
		end
	end

	// register strobes
	assign wr_cnt_lo  = reg_wr_i && (reg_addr_i == LWT_CNT_LO_OFS);
	assign wr_cnt_mid = reg_wr_i && (reg_addr_i == LWT_CNT_MID_OFS);
	assign wr_cnt_hi  = reg_wr_i && (reg_addr_i == LWT_CNT_HI_OFS);
	assign wr_cap_ctl = reg_wr_i && (reg_addr_i == LWT_CAP_CTL_OFS);
	assign wr_cap_st  = reg_wr_i && (reg_addr_i == LWT_CAP_ST_OFS);
	assign rd_cnt_lo  = reg_rd_i && (reg_addr_i == LWT_CNT_LO_OFS);

	// a low compare write only counts while no load is in flight
	assign load_ok = wr_cnt_lo && !load_pend_ff;

	// snapshot on low byte read keeps the three bytes coherent
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			snap_ff <= LWT_CNT_RST;
		end else if (rd_cnt_lo) begin
			snap_ff <= vis_cnt_ff;
		end
	end

	// compare staging bytes; high and middle are plain latches
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmp_hi_ff  <= LWT_BYTE_RST;
			cmp_mid_ff <= LWT_BYTE_RST;
			cmp_lo_ff  <= LWT_BYTE_RST;
		end else begin
			if (wr_cnt_hi) begin
				cmp_hi_ff <= reg_wdata_i;
			end
			if (wr_cnt_mid) begin
				cmp_mid_ff <= reg_wdata_i;
			end
			if (load_ok) begin
				cmp_lo_ff <= reg_wdata_i;
			end
		end
	end

	// load transfer: the new value reaches the slow side on the next tick,
	// which is why a value too close to the count can be passed by
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			load_pend_ff <= 1'b0;
			cmp_ff       <= LWT_CMP_RST;
		end else if (load_pend_ff && slow_rise) begin
			load_pend_ff <= 1'b0;
			cmp_ff       <= {cmp_hi_ff, cmp_mid_ff, cmp_lo_ff};
		end else if (load_ok) begin
			load_pend_ff <= 1'b1;
		end
	end

	// compare event on the tick at which the count equals the compare value
	assign cmp_event = running && slow_rise && (cnt_ff == cmp_ff);

	// flag is sticky; a new event wins over a clear in the same cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmp_flag_ff <= 1'b0;
		end else if (cmp_event) begin
			cmp_flag_ff <= 1'b1;
		end else if (compare_flag_clr_i) begin
			cmp_flag_ff <= 1'b0;
		end
	end

	// request, dma pulse and wake are registered so outputs come from flops
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_req_ff <= 1'b0;
			dma_ff     <= 1'b0;
			wake_ff    <= 1'b0;
		end else begin
			irq_req_ff <= (cmp_flag_ff | cmp_event) & compare_irq_enable_i;
			dma_ff     <= cmp_event;
			wake_ff    <= cmp_event && sleeping;
		end
	end

	// capture is live only for ports 0..2 with an existing pin
	assign cap_en = (cap_port_ff != LWT_PORT_OFF) &&
		((cap_port_ff != LWT_PORT_TWO) || (cap_pin_ff < LWT_PIN_LIM_P2));

	// pin can only move while capture is off, or when turning it off
	assign ctl_ok = wr_cap_ctl && ((cap_port_ff == LWT_PORT_OFF) ||
		(reg_wdata_i[LWT_PORT_MSB:LWT_PORT_LSB] == LWT_PORT_OFF));

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cap_port_ff <= LWT_PORT_OFF;
			cap_pin_ff  <= LWT_PIN_RST;
		end else if (ctl_ok) begin
			cap_port_ff <= reg_wdata_i[LWT_PORT_MSB:LWT_PORT_LSB];
			cap_pin_ff  <= reg_wdata_i[LWT_PIN_MSB:LWT_PIN_LSB];
		end
	end

	// selected pin flag; gated so an out of range index is never read
	assign pin_index = {cap_port_ff, cap_pin_ff};
	assign pin_sel   = cap_en ? port_irq_flags_i[pin_index] : 1'b0;

	// pin flag is synchronised, then sampled once per slow tick
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_s1_ff   <= 1'b0;
			pin_s2_ff   <= 1'b0;
			pin_prev_ff <= 1'b0;
		end else begin
			pin_s1_ff <= pin_sel;
			pin_s2_ff <= pin_s1_ff;
			if (slow_rise) begin
				pin_prev_ff <= pin_s2_ff;
			end
		end
	end

	// a flag left high never rises again; software must clear it to re-arm
	assign cap_event = running && slow_rise && pin_s2_ff && !pin_prev_ff && !cap_valid_ff;

	// captured value is the count after the tick, one past the pin event
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cap_val_ff <= LWT_CNT_RST;
		end else if (cap_event) begin
			cap_val_ff <= cnt_inc;
		end
	end

	// valid is sticky; writing zero clears it, a capture in that cycle wins
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cap_valid_ff <= 1'b0;
		end else if (cap_event) begin
			cap_valid_ff <= 1'b1;
		end else if (wr_cap_st && !reg_wdata_i[0]) begin
			cap_valid_ff <= 1'b0;
		end
	end

	// read selection; unmapped addresses read as zero
	always_comb begin
		rd_mux = LWT_BYTE_RST;
		case (reg_addr_i)
			LWT_CNT_LO_OFS:  rd_mux = vis_cnt_ff[7:0];
			LWT_CNT_MID_OFS: rd_mux = snap_ff[15:8];
			LWT_CNT_HI_OFS:  rd_mux = snap_ff[23:16];
			LWT_LOAD_ST_OFS: rd_mux = {LWT_PAD7, !load_pend_ff};
			LWT_CAP_CTL_OFS: rd_mux = {LWT_PAD3, cap_port_ff, cap_pin_ff};
			LWT_CAP_ST_OFS:  rd_mux = {LWT_PAD7, cap_valid_ff};
			LWT_CAP_LO_OFS:  rd_mux = cap_val_ff[7:0];
			LWT_CAP_MID_OFS: rd_mux = cap_val_ff[15:8];
			LWT_CAP_HI_OFS:  rd_mux = cap_val_ff[23:16];
			default:         rd_mux = LWT_BYTE_RST;
		endcase
	end

	// read data is held until the next read strobe
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff <= LWT_BYTE_RST;
		end else if (reg_rd_i) begin
			rdata_ff <= rd_mux;
		end
	end

	// outputs straight from flops, dma index straight from the parameter
	assign reg_rdata_o         = rdata_ff;
	assign compare_irq_flag_o  = cmp_flag_ff;
	assign compare_irq_req_o   = irq_req_ff;
	assign dma_trigger_o       = dma_ff;
	assign dma_trigger_index_o = DMA_TRIG_INDEX;
	assign wake_o              = wake_ff;
	assign slow_clock_level_o  = slow_s2_ff;

endmodule

// [testbench/lwt_top_props.sv]
// concurrent checks on the wake timer ports
// assumes it is bound onto lwt_top, one clk_i domain with async rst_i
module lwt_top_props
	import lwt_pkg::*;
#(
	parameter logic [4:0] DMA_TRIG_INDEX = LWT_DMA_IDX_B
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        slow_clk_i,
	input lwt_pmode_e       power_mode_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        compare_irq_enable_i,
	input wire logic        compare_flag_clr_i,
	input wire logic        compare_irq_flag_o,
	input wire logic        compare_irq_req_o,
	input wire logic        dma_trigger_o,
	input wire logic [4:0]  dma_trigger_index_o,
	input wire logic        wake_o,
	input wire logic        slow_clock_level_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// single domain, so clocking and reset are given once
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_dma_index: assert property (dma_trigger_index_o == DMA_TRIG_INDEX)
		else $error("dma trigger index differs from the variant value");
	chk_dma_single: assert property (dma_trigger_o |=> !dma_trigger_o)
		else $error("dma trigger longer than one cycle");
	chk_dma_slow_high: assert property (dma_trigger_o |-> slow_clock_level_o)
		else $error("compare event away from a slow clock rise");
	chk_wake_mode: assert property (wake_o |-> $past(power_mode_i) inside {LWT_PM_LIGHT, LWT_PM_MEDIUM})
		else $error("wake pulse outside light or medium sleep");
	chk_wake_with_dma: assert property (wake_o |-> dma_trigger_o)
		else $error("wake pulse without a compare event");
	chk_flag_on_event: assert property ($rose(compare_irq_flag_o) |-> dma_trigger_o)
		else $error("compare flag set without a compare event");
	chk_flag_sticky: assert property (compare_irq_flag_o && !compare_flag_clr_i |=> compare_irq_flag_o)
		else $error("compare flag dropped without a clear");
	chk_req_gated: assert property (compare_irq_req_o |-> $past(compare_irq_enable_i))
		else $error("compare request while the enable was low");
	chk_level_sync: assert property (slow_clock_level_o == $past(slow_clk_i, 2))
		else $error("slow clock level not two stages behind its input");
	chk_load_pad: assert property (reg_rd_i && reg_addr_i == LWT_LOAD_ST_OFS |=> reg_rdata_o[7:1] == LWT_PAD7)
		else $error("load status reserved bits not zero");
endmodule

// [testbench/lwt_top_tb_top.sv]
// self-checking bench for the wake timer: register rows, snapshot, compare, capture, modes
// assumes lwt_pkg is compiled first; the slow clock is driven here and rests low between ticks
`define CHK(n, e, g) check(n, e, g)
module lwt_top_tb_top
	import lwt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [15:0] addr; logic [7:0] data;} lwt_row_s;
	localparam int LIMIT = 20000;
	logic        clk_i, rst_i, slow_clk_i, reg_wr_i, reg_rd_i;
	logic        compare_irq_enable_i, compare_flag_clr_i, compare_irq_flag_o, compare_irq_req_o;
	logic        dma_trigger_o, wake_o, slow_clock_level_o;
	logic [15:0] reg_addr_i;
	logic [7:0]  reg_wdata_i, reg_rdata_o;
	logic [23:0] port_irq_flags_i, exp_cnt;
	logic [4:0]  dma_trigger_index_o;
	lwt_pmode_e  power_mode_i;
	int          errors = 0, samples_checked = 0, cycles = 0, dma_seen = 0, wake_seen = 0;
	// reset values, read-only padding and unmapped places
	lwt_row_s    rows [11] = '{'{LWT_CNT_LO_OFS, 8'h00}, '{LWT_CNT_MID_OFS, 8'h00},
		'{LWT_CNT_HI_OFS, 8'h00}, '{LWT_LOAD_ST_OFS, 8'h01}, '{LWT_CAP_CTL_OFS, 8'h1f},
		'{LWT_CAP_ST_OFS, 8'h00}, '{LWT_CAP_LO_OFS, 8'h00}, '{LWT_CAP_MID_OFS, 8'h00},
		'{LWT_CAP_HI_OFS, 8'h00}, '{16'h0000, 8'h00}, '{16'h62b5, 8'h00}};

	lwt_top #(.DMA_TRIG_INDEX(LWT_DMA_IDX_B)) DUT (
		.clk_i, .rst_i, .slow_clk_i, .power_mode_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
		.reg_wdata_i, .reg_rdata_o, .compare_irq_enable_i, .compare_flag_clr_i,
		.port_irq_flags_i, .compare_irq_flag_o, .compare_irq_req_o, .dma_trigger_o,
		.dma_trigger_index_o, .wake_o, .slow_clock_level_o
	);

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// watchdog and pulse tally; a hang ends in the same verdict path
	always @(posedge clk_i) begin
		cycles++;
		dma_seen += dma_trigger_o;
		wake_seen += wake_o;
		if (cycles == LIMIT) begin
			errors++;
			print_verdict();
		end
	end

	task automatic check(input string n, input logic [23:0] e, input logic [23:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// strobes are one cycle wide, so back to back calls leave an idle cycle
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i) #1 reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(posedge clk_i) #1 reg_wr_i = 1'b0;
	endtask

	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_i) #1 reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(posedge clk_i) #1 reg_rd_i = 1'b0;
		check($sformatf("reg %h", a), {16'h0000, e}, {16'h0000, reg_rdata_o});
	endtask

	// slow periods shortened to eleven clocks; deepest sleep holds the count at zero
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk_i) #1 slow_clk_i = 1'b1;
			repeat (5) @(posedge clk_i);
			#1 slow_clk_i = 1'b0;
			repeat (5) @(posedge clk_i);
			exp_cnt = (power_mode_i == LWT_PM_DEEPEST) ? LWT_CNT_RST : exp_cnt + LWT_CNT_ONE;
		end
		repeat (3) @(posedge clk_i);
		// hand back off the edge, so callers never drive or sample inside it
		#1;
	endtask

	task automatic print_verdict();
		$display("checked %0d, errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		rst_i = 1'b1;
		slow_clk_i = 1'b0;
		power_mode_i = LWT_PM_ACTIVE;
		{reg_wr_i, reg_rd_i, compare_irq_enable_i, compare_flag_clr_i} = 4'h0;
		reg_addr_i = 16'h0000;
		reg_wdata_i = 8'h00;
		port_irq_flags_i = 24'h000000;
		exp_cnt = LWT_CNT_RST;
		repeat (3) @(posedge clk_i);
		#1 rst_i = 1'b0;
		foreach (rows[i]) rdc(rows[i].addr, rows[i].data);
		`CHK("dma index", LWT_DMA_IDX_B, dma_trigger_index_o);
		// mid and high bytes come from the snapshot taken by the low byte read
		ticks(255);
		rdc(LWT_CNT_LO_OFS, 8'hff);
		ticks(1);
		rdc(LWT_CNT_MID_OFS, 8'h00);
		rdc(LWT_CNT_LO_OFS, exp_cnt[7:0]);
		rdc(LWT_CNT_MID_OFS, exp_cnt[15:8]);
		rdc(LWT_CNT_HI_OFS, exp_cnt[23:16]);
		`CHK("early match", 0, dma_seen);
		// compare six ahead in light sleep; a late low byte write must be dropped
		compare_irq_enable_i = 1'b1;
		power_mode_i = LWT_PM_LIGHT;
		wr(LWT_CNT_HI_OFS, 8'haa);
		wr(LWT_CNT_HI_OFS, exp_cnt[23:16]);
		wr(LWT_CNT_MID_OFS, exp_cnt[15:8]);
		wr(LWT_CNT_LO_OFS, exp_cnt[7:0] + 8'h06);
		rdc(LWT_LOAD_ST_OFS, 8'h00);
		wr(LWT_CNT_LO_OFS, 8'h03);
		ticks(1);
		rdc(LWT_LOAD_ST_OFS, 8'h01);
		ticks(5);
		`CHK("match too soon", 0, dma_seen);
		ticks(1);
		`CHK("dma pulses", 1, dma_seen);
		`CHK("wake pulses", 1, wake_seen);
		`CHK("cmp flag", 1, compare_irq_flag_o);
		`CHK("cmp request", 1, compare_irq_req_o);
		compare_irq_enable_i = 1'b0;
		compare_flag_clr_i = 1'b1;
		@(posedge clk_i) #1 compare_flag_clr_i = 1'b0;
		`CHK("flag cleared", 0, compare_irq_flag_o);
		`CHK("request gated", 0, compare_irq_req_o);
		// after light sleep the visible count stays stale until one slow rise
		power_mode_i = LWT_PM_ACTIVE;
		rdc(LWT_CNT_LO_OFS, 8'h00);
		ticks(1);
		rdc(LWT_CNT_LO_OFS, exp_cnt[7:0]);
		// capture on port 0 pin 2, then a second flag edge while still valid
		wr(LWT_CAP_CTL_OFS, 8'h02);
		rdc(LWT_CAP_CTL_OFS, 8'h02);
		port_irq_flags_i[2] = 1'b1;
		ticks(1);
		rdc(LWT_CAP_ST_OFS, 8'h01);
		rdc(LWT_CAP_LO_OFS, exp_cnt[7:0]);
		rdc(LWT_CAP_MID_OFS, exp_cnt[15:8]);
		rdc(LWT_CAP_HI_OFS, exp_cnt[23:16]);
		power_mode_i = LWT_PM_MEDIUM;
		port_irq_flags_i[2] = 1'b0;
		ticks(1);
		port_irq_flags_i[2] = 1'b1;
		ticks(1);
		rdc(LWT_CAP_LO_OFS, exp_cnt[7:0] - 8'h02);
		wr(LWT_CAP_ST_OFS, 8'h00);
		wr(LWT_CAP_ST_OFS, 8'h01);
		rdc(LWT_CAP_ST_OFS, 8'h00);
		// pin is locked while enabled; port 2 pin 6 is an invalid choice
		wr(LWT_CAP_CTL_OFS, 8'h05);
		rdc(LWT_CAP_CTL_OFS, 8'h02);
		wr(LWT_CAP_CTL_OFS, 8'h18);
		wr(LWT_CAP_CTL_OFS, 8'h16);
		rdc(LWT_CAP_CTL_OFS, 8'h16);
		// one tick with the gated flag low, so a live pin would see a real rise
		ticks(1);
		port_irq_flags_i[22] = 1'b1;
		ticks(1);
		rdc(LWT_CAP_ST_OFS, 8'h00);
		// deepest sleep clears the count, which restarts on return
		power_mode_i = LWT_PM_DEEPEST;
		ticks(2);
		rdc(LWT_CNT_LO_OFS, 8'h00);
		power_mode_i = LWT_PM_IDLE;
		ticks(3);
		rdc(LWT_CNT_LO_OFS, exp_cnt[7:0]);
		// reset again mid-run: load, capture and compare state return to defaults
		@(posedge clk_i) #1 rst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		#1 rst_i = 1'b0;
		exp_cnt = LWT_CNT_RST;
		rdc(LWT_LOAD_ST_OFS, 8'h01);
		rdc(LWT_CAP_CTL_OFS, 8'h1f);
		rdc(LWT_CNT_LO_OFS, 8'h00);
		ticks(1);
		rdc(LWT_CNT_LO_OFS, exp_cnt[7:0]);
		`CHK("dma after reset", 1, dma_seen);
		print_verdict();
	end
endmodule

bind lwt_top lwt_top_props #(.DMA_TRIG_INDEX(DMA_TRIG_INDEX)) u_props (
	.clk_i, .rst_i, .slow_clk_i, .power_mode_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o,
	.compare_irq_enable_i, .compare_flag_clr_i, .compare_irq_flag_o, .compare_irq_req_o,
	.dma_trigger_o, .dma_trigger_index_o, .wake_o, .slow_clock_level_o
);
